// [core/tsense_cfg_pkg.sv]
// Constants, register map and sequencer states of the conversion config bank
package tsense_cfg_pkg;

  // Register command bytes
  localparam logic [7:0] ADDR_MAIN_CFG = 8'h03;
  localparam logic [7:0] ADDR_CONV_RATE = 8'h04;
  localparam logic [7:0] ADDR_CHAN_EN = 8'h05;
  localparam logic [7:0] ADDR_FILTER = 8'h06;
  localparam logic [7:0] ADDR_ONE_SHOT = 8'h0f;

  // Values after reset
  localparam logic [7:0] MAIN_CFG_RST = 8'h03;
  localparam logic [7:0] CONV_RATE_RST = 8'h02;
  localparam logic [7:0] CHAN_EN_RST = 8'h1f;
  localparam logic [7:0] FILTER_RST = 8'h0f;

  // Field positions in the main configuration register
  localparam int STANDBY_BIT = 6;
  localparam int Q4_BIT = 1;
  localparam int Q3_BIT = 0;
  // Field positions in the filter register
  localparam int F2_LSB = 2;
  localparam int F1_LSB = 0;
  // Fraction bits of a remote low byte that exist only when filtering
  localparam int FRAC_HI = 4;
  localparam int FRAC_LO = 3;

  // Rate codes
  localparam logic [1:0] RATE_CONT = 2'h0;
  localparam logic [1:0] RATE_364MS = 2'h1;
  localparam logic [1:0] RATE_1S = 2'h2;
  localparam logic [1:0] RATE_2S5 = 2'h3;
  // Filter off code
  localparam logic [1:0] FILT_OFF = 2'h0;

  // Channel numbering and the no-channel marker
  localparam int NUM_CHAN = 5;
  localparam logic [2:0] CH_LOCAL = 3'h0;
  localparam logic [2:0] CH_NONE = 3'h7;

  // Clock rate and sequence intervals
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned RATE1_TIME_US = 364000;
  localparam int unsigned RATE2_TIME_US = 1000000;
  localparam int unsigned RATE3_TIME_US = 2500000;
  localparam int unsigned RATE1_CYC = RATE1_TIME_US * CLK_MHZ;
  localparam int unsigned RATE2_CYC = RATE2_TIME_US * CLK_MHZ;
  localparam int unsigned RATE3_CYC = RATE3_TIME_US * CLK_MHZ;
  // Width of the interval counter
  localparam int TIMER_W = 29;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_WAIT = 2'b10
  } seq_e;

endpackage : tsense_cfg_pkg

// [core/interval_timer.sv]
// Down counter that marks the end of a conversion interval
`timescale 1ns/100ps
module interval_timer
  import tsense_cfg_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [W-1:0] limit,
  output logic expired
);

  // Whole state of the timer
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_s;

  tmr_s s_r; // Registered state
  tmr_s s_nxt; // Next state

  // Load restarts the interval, otherwise count down to zero and hold
  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.cnt = limit - W'(1);
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - W'(1);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Interval over once the count sits at zero
  assign expired = (s_r.cnt == '0);

endmodule : interval_timer

// [core/tsense_conv_cfg.sv]
// Conversion configuration registers and channel sequencer
//
// Notes on behaviour
// - Standby bit stops conversions; one-shot starts one sequence
// - Config bit 1 enables remote 4 queue
// - Config bit 0 enables remote 3 queue
// - Unimplemented register bits always read zero
// - Rate code picks continuous or fixed interval
// - Convert enabled channels, then idle until interval
// - Continuous mode restarts right after sequence end
// - Disabled channels are skipped by the sequencer
// - Timed intervals fixed; continuous period shrinks
// - Channel enables bits 4..0, reset 0x1f
// - Remote 2 filter field in bits 3..2
// - Remote 1 filter in bits 1..0, reset 0x0f
// - Filter off zeroes sixteenth and 32nd bits
// - One-shot write starts sequence, data discarded
`timescale 1ns/100ps
module tsense_conv_cfg
  import tsense_cfg_pkg::*;
#(
  parameter int unsigned INTERVAL1_CYCLES = RATE1_CYC,
  parameter int unsigned INTERVAL2_CYCLES = RATE2_CYC,
  parameter int unsigned INTERVAL3_CYCLES = RATE3_CYC
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output logic SOFTWARE_STANDBY,
  output logic REMOTE4_QUEUE_ENABLE,
  output logic REMOTE3_QUEUE_ENABLE,
  output logic [1:0] RATE_SELECT,
  output logic [4:0] CONVERT_ENABLE,
  output logic [1:0] REMOTE2_FILTER_MODE,
  output logic [1:0] REMOTE1_FILTER_MODE,
  input wire logic CONV_DONE,
  output logic CONV_START,
  output logic [2:0] CONV_CHANNEL,
  output logic BUSY,
  input wire logic [7:0] REM1_LSB_RAW,
  input wire logic [7:0] REM2_LSB_RAW,
  output logic [7:0] REM1_LSB,
  output logic [7:0] REM2_LSB
);

  // Whole state of the block
  typedef struct packed {
    logic standby; // Software standby
    logic q4; // Remote 4 fault queue enable
    logic q3; // Remote 3 fault queue enable
    logic [1:0] rate; // Rate select
    logic [4:0] ce; // Channel conversion enables
    logic [1:0] f2; // Remote 2 filter mode
    logic [1:0] f1; // Remote 1 filter mode
    logic [7:0] rdata; // Read data
    logic rvalid; // Read data valid
    seq_e st; // Sequencer state
    logic [2:0] chan; // Channel in conversion
    logic start; // Conversion start pulse
    logic busy; // Sequence in progress
    logic [4:0] ce_prev; // Enables as they stood one cycle back
    logic [7:0] lsb1; // Remote 1 low byte as seen by the host
    logic [7:0] lsb2; // Remote 2 low byte as seen by the host
  } state_s;

  // State after reset
  localparam state_s RST_STATE = '{
    standby: MAIN_CFG_RST[STANDBY_BIT],
    q4: MAIN_CFG_RST[Q4_BIT],
    q3: MAIN_CFG_RST[Q3_BIT],
    rate: CONV_RATE_RST[1:0],
    ce: CHAN_EN_RST[4:0],
    f2: FILTER_RST[F2_LSB+1:F2_LSB],
    f1: FILTER_RST[F1_LSB+1:F1_LSB],
    rdata: 8'h00,
    rvalid: 1'b0,
    st: SEQ_IDLE,
    chan: CH_LOCAL,
    start: 1'b0,
    busy: 1'b0,
    ce_prev: CHAN_EN_RST[4:0],
    lsb1: 8'h00,
    lsb2: 8'h00
  };

  state_s s_r; // Registered state
  state_s s_nxt; // Next state
  logic oneshot_wr; // Host write to the one-shot register
  logic tmr_load; // Restart the interval timer
  logic [TIMER_W-1:0] tmr_limit; // Interval length for the current rate
  logic tmr_expired; // Interval has run out

  // Lowest enabled channel at or above a start index
  function automatic logic [2:0] next_en(input logic [4:0] en,
                                         input logic [2:0] from);
    logic [2:0] r;
    r = CH_NONE;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : next_en

  assign oneshot_wr = REG_WR && (REG_ADDR == ADDR_ONE_SHOT);

  // Interval length chosen by the rate field
  always_comb begin
    unique case (s_r.rate)
      RATE_364MS: tmr_limit = TIMER_W'(INTERVAL1_CYCLES);
      RATE_1S: tmr_limit = TIMER_W'(INTERVAL2_CYCLES);
      RATE_2S5: tmr_limit = TIMER_W'(INTERVAL3_CYCLES);
      RATE_CONT: tmr_limit = TIMER_W'(1);
    endcase
  end

  // Timer that fixes the spacing of timed sequences
  interval_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk(MCLK),
    .rst_b(RST_B),
    .load(tmr_load),
    .limit(tmr_limit),
    .expired(tmr_expired)
  );

  // Register access, sequencer and low-byte masking
  always_comb begin
    logic begin_seq;
    logic [2:0] nx;
    begin_seq = 1'b0;
    nx = CH_NONE;
    tmr_load = 1'b0;
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.rvalid = REG_RD;

    // Read mux, unmapped and write-only addresses read zero
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_MAIN_CFG: s_nxt.rdata = {1'b0, s_r.standby, 4'h0, s_r.q4, s_r.q3};
        ADDR_CONV_RATE: s_nxt.rdata = {6'h00, s_r.rate};
        ADDR_CHAN_EN: s_nxt.rdata = {3'h0, s_r.ce};
        ADDR_FILTER: s_nxt.rdata = {4'h0, s_r.f2, s_r.f1};
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // Register writes; one-shot data is not kept anywhere
    if (REG_WR) begin
      unique case (REG_ADDR)
        ADDR_MAIN_CFG: begin
          s_nxt.standby = REG_WDATA[STANDBY_BIT];
          s_nxt.q4 = REG_WDATA[Q4_BIT];
          s_nxt.q3 = REG_WDATA[Q3_BIT];
        end
        ADDR_CONV_RATE: begin
          s_nxt.rate = REG_WDATA[1:0];
        end
        ADDR_CHAN_EN: begin
          s_nxt.ce = REG_WDATA[4:0];
        end
        ADDR_FILTER: begin
          s_nxt.f2 = REG_WDATA[F2_LSB+1:F2_LSB];
          s_nxt.f1 = REG_WDATA[F1_LSB+1:F1_LSB];
        end
        default: begin
          // Other addresses store nothing
        end
      endcase
    end

    // Sequencer
    unique case (s_r.st)
      SEQ_IDLE: begin
        if (!s_r.standby || oneshot_wr) begin
          begin_seq = 1'b1;
        end
      end
      SEQ_CONV: begin
        if (CONV_DONE) begin
          nx = next_en(s_r.ce, 3'(s_r.chan + 3'h1));
          if (nx != CH_NONE) begin
            s_nxt.chan = nx;
            s_nxt.start = 1'b1;
          end else if (s_r.standby) begin
            s_nxt.st = SEQ_IDLE;
          end else if (s_r.rate == RATE_CONT) begin
            begin_seq = 1'b1;
          end else begin
            s_nxt.st = SEQ_WAIT;
          end
        end
      end
      SEQ_WAIT: begin
        if (s_r.standby) begin
          s_nxt.st = SEQ_IDLE;
        end else if (tmr_expired) begin
          begin_seq = 1'b1;
        end
      end
      default: begin
        s_nxt.st = SEQ_IDLE;
      end
    endcase

    // Start of a sequence, from the lowest enabled channel
    if (begin_seq) begin
      tmr_load = 1'b1;
      nx = next_en(s_r.ce, CH_LOCAL);
      if (nx != CH_NONE) begin
        s_nxt.st = SEQ_CONV;
        s_nxt.chan = nx;
        s_nxt.start = 1'b1;
      end else if (s_r.standby || (s_r.rate == RATE_CONT)) begin
        s_nxt.st = SEQ_IDLE;
      end else begin
        s_nxt.st = SEQ_WAIT;
      end
    end
    s_nxt.busy = (s_nxt.st == SEQ_CONV);
    // Enables one cycle back, for checking the chosen channel
    s_nxt.ce_prev = s_r.ce;

    s_nxt.lsb1 = {REM1_LSB_RAW[7:5],
                  (s_r.f1 != FILT_OFF) ? REM1_LSB_RAW[FRAC_HI:FRAC_LO] : 2'h0,
                  3'h0};
    s_nxt.lsb2 = {REM2_LSB_RAW[7:5],
                  (s_r.f2 != FILT_OFF) ? REM2_LSB_RAW[FRAC_HI:FRAC_LO] : 2'h0,
                  3'h0};
  end

  // State register
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign REG_RDATA = s_r.rdata;
  assign REG_RVALID = s_r.rvalid;
  assign SOFTWARE_STANDBY = s_r.standby;
  assign REMOTE4_QUEUE_ENABLE = s_r.q4;
  assign REMOTE3_QUEUE_ENABLE = s_r.q3;
  assign RATE_SELECT = s_r.rate;
  assign CONVERT_ENABLE = s_r.ce;
  assign REMOTE2_FILTER_MODE = s_r.f2;
  assign REMOTE1_FILTER_MODE = s_r.f1;
  assign CONV_START = s_r.start;
  assign CONV_CHANNEL = s_r.chan;
  assign BUSY = s_r.busy;
  assign REM1_LSB = s_r.lsb1;
  assign REM2_LSB = s_r.lsb2;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  a_standby_hold: assert property (
    s_r.standby && (s_r.st == SEQ_IDLE) && !oneshot_wr |=> !CONV_START)
    else $error("conversion started in standby without one-shot");
  a_q4_write: assert property (
    REG_WR && (REG_ADDR == ADDR_MAIN_CFG) |=>
      REMOTE4_QUEUE_ENABLE == $past(REG_WDATA[Q4_BIT]))
    else $error("remote 4 queue enable not stored");
  a_q3_write: assert property (
    REG_WR && (REG_ADDR == ADDR_MAIN_CFG) |=>
      REMOTE3_QUEUE_ENABLE == $past(REG_WDATA[Q3_BIT]))
    else $error("remote 3 queue enable not stored");
  a_rsvd_zero: assert property (
    REG_RD && (REG_ADDR == ADDR_CHAN_EN) |=>
      REG_RVALID && (REG_RDATA[7:5] == 3'h0))
    else $error("reserved enable bits read nonzero");
  a_wait_quiet: assert property (
    (s_r.st == SEQ_WAIT) && !tmr_expired |=> !CONV_START)
    else $error("sequence started before interval end");
  a_skip_off: assert property (
    CONV_START |-> s_r.ce_prev[CONV_CHANNEL])
    else $error("disabled channel converted");
  a_cont_restart: assert property (
    (s_r.st == SEQ_CONV) && CONV_DONE && !s_r.standby &&
      (s_r.rate == RATE_CONT) &&
      (next_en(s_r.ce, 3'(s_r.chan + 3'h1)) == CH_NONE) && s_r.ce[0]
      |=> CONV_START && (CONV_CHANNEL == CH_LOCAL))
    else $error("continuous mode did not restart at local");
  a_oneshot_go: assert property (
    s_r.standby && (s_r.st == SEQ_IDLE) && oneshot_wr && (s_r.ce != 5'h00)
      |=> CONV_START ##1 BUSY)
    else $error("one-shot write did not start a sequence");
  a_filt_off: assert property (
    (s_r.f1 == FILT_OFF) |=> REM1_LSB[FRAC_HI:FRAC_LO] == 2'h0)
    else $error("fraction bits shown with filter off");
  a_filt_on: assert property (
    (s_r.f2 != FILT_OFF) |=> REM2_LSB == ($past(REM2_LSB_RAW) & 8'hf8))
    else $error("filtered fraction not passed");

  c_oneshot: cover property (s_r.standby && oneshot_wr ##1 CONV_START);
  c_cont: cover property ((s_r.rate == RATE_CONT) && CONV_DONE ##1
                          CONV_START);
  c_wait: cover property ((s_r.st == SEQ_WAIT) ##1 CONV_START);
  c_skip: cover property (CONV_START && (CONV_CHANNEL == 3'h4) &&
                          !s_r.ce_prev[3]);

endmodule : tsense_conv_cfg

// [verif/frontend_model.sv]
// Front-end model that answers each conversion start with a done pulse
`timescale 1ns/100ps
module frontend_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic conv_start,
  input wire logic [3:0] lat,
  output logic conv_done
);
  // Cycles left in the running conversion
  logic [3:0] left_r;

  // Load on start, pulse done once when the count runs out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left_r <= 4'h0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (left_r == 4'h1);
      if (conv_start) begin
        left_r <= lat;
      end else if (left_r != 4'h0) begin
        left_r <= left_r - 4'h1;
      end
    end
  end
endmodule : frontend_model

// [verif/testbench.sv]
// Self-checking bench for the conversion configuration bank
`timescale 1ns/100ps
module testbench;
  import tsense_cfg_pkg::*;
  // Shortened intervals for rate codes 1..3
  localparam int unsigned IV[4] = '{0, 200, 400, 800};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] raw1 = 8'h00;
  logic [7:0] raw2 = 8'h00;
  logic [3:0] lat = 4'h2;
  logic [7:0] rdata, lsb1, lsb2;
  logic rvalid, standby, q4, q3, done, start, busy;
  logic [1:0] rate, f2, f1;
  logic [4:0] en;
  logic [2:0] chan;
  int failures = 0;
  int num_checks = 0;
  int seed = 41;
  int cyc = 0;
  // Register places, readback masks and legal filter codes
  logic [7:0] ra[6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h07};
  logic [7:0] rv[6] = '{8'h03, 8'h02, 8'h1f, 8'h0f, 8'h00, 8'h00};
  logic [7:0] mk[4] = '{8'h43, 8'h03, 8'h1f, 8'h0f};
  logic [1:0] fcode[3] = '{2'h0, 2'h1, 2'h3};
  // Log of conversion starts: channel and cycle
  logic [2:0] ch_q[$];
  int t_q[$];

  always #4 mclk = ~mclk;

  tsense_conv_cfg #(.INTERVAL1_CYCLES(IV[1]), .INTERVAL2_CYCLES(IV[2]),
    .INTERVAL3_CYCLES(IV[3])) dut_u (
    .MCLK(mclk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .SOFTWARE_STANDBY(standby), .REMOTE4_QUEUE_ENABLE(q4),
    .REMOTE3_QUEUE_ENABLE(q3), .RATE_SELECT(rate), .CONVERT_ENABLE(en),
    .REMOTE2_FILTER_MODE(f2), .REMOTE1_FILTER_MODE(f1), .CONV_DONE(done),
    .CONV_START(start), .CONV_CHANNEL(chan), .BUSY(busy),
    .REM1_LSB_RAW(raw1), .REM2_LSB_RAW(raw2), .REM1_LSB(lsb1),
    .REM2_LSB(lsb2));

  frontend_model fe_u (.clk(mclk), .rst_b(rst_b), .conv_start(start),
    .lat(lat), .conv_done(done));

  // Record every conversion start with its cycle number
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (start === 1'b1) begin
      ch_q.push_back(chan);
      t_q.push_back(cyc);
    end
  end

  // Low byte as it should look for a filter mode
  function automatic logic [7:0] lsb_exp(logic [7:0] r, logic [1:0] m);
    return r & ((m == 2'h0) ? 8'he0 : 8'hf8);
  endfunction : lsb_exp

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic timeout(string what);
    failures++;
    $display("unexpected %s: expected progress seen timeout", what);
    summarize();
  endtask : timeout

  // Wait n edges, then settle just after the last one
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    tick(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(logic [7:0] a, logic [7:0] exp);
    tick(1);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk("read valid", 1, rvalid);
    chk("read data", exp, rdata);
  endtask : reg_rd

  // Bounded wait for the sequencer to go quiet
  task automatic wait_idle();
    int i;
    for (i = 0; i < 5000 && busy !== 1'b0; i++) tick(1);
    if (busy !== 1'b0) timeout("busy");
  endtask : wait_idle

  // Two whole sequences: channel order and start-to-start period
  task automatic seq_check(logic [4:0] e, int n, int per);
    int lst[$];
    int i;
    for (i = 0; i < 5; i++) if (e[i]) lst.push_back(i);
    for (i = 0; i < 6000 && ch_q.size() < 2 * n + 1; i++) tick(1);
    if (ch_q.size() < 2 * n + 1) timeout("starts");
    for (i = 0; i < 2 * n; i++) begin
      chk("channel", lst[i % n], ch_q[i]);
    end
    chk("period", per, t_q[n] - t_q[0]);
    chk("period", per, t_q[2 * n] - t_q[n]);
  endtask : seq_check

  initial begin
    logic [7:0] w[4];
    logic [7:0] d;
    logic [4:0] e;
    int n;
    repeat (16) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    // Reset contents, one-shot and unmapped places read zero
    for (int i = 0; i < 6; i++) reg_rd(ra[i], rv[i]);
    // Random writes, readback masks and field outputs
    for (int i = 0; i < 12; i++) begin
      for (int k = 0; k < 4; k++) w[k] = 8'($random(seed));
      w[3][3:0] = {fcode[w[3][5:4] % 3], fcode[w[3][7:6] % 3]};
      for (int k = 0; k < 4; k++) reg_wr(ra[k], w[k]);
      reg_wr({3'h1, w[0][4:0]}, 8'hff);
      for (int k = 0; k < 4; k++) reg_rd(ra[k], w[k] & mk[k]);
      chk("flags", {w[0][6], w[0][1:0]}, {standby, q4, q3});
      chk("rate", w[1][1:0], rate);
      chk("enables", w[2][4:0], en);
      chk("filters", w[3][3:0], {f2, f1});
      raw1 = 8'($random(seed));
      raw2 = 8'($random(seed));
      tick(2);
      chk("lsb1", lsb_exp(raw1, w[3][1:0]), lsb1);
      chk("lsb2", lsb_exp(raw2, w[3][3:2]), lsb2);
    end
    // Every rate code, all channels and a random subset
    for (int rc = 0; rc < 4; rc++) begin
      for (int j = 0; j < 2; j++) begin
        d = 8'($random(seed));
        e = (j == 0) ? 5'h1f : ((d[4:0] == 5'h0) ? 5'h12 : d[4:0]);
        lat = 4'(1 + d[7:5] % 6);
        reg_wr(ADDR_MAIN_CFG, 8'h40);
        wait_idle();
        reg_wr(ADDR_CONV_RATE, rc[7:0]);
        reg_wr(ADDR_CHAN_EN, {3'h0, e});
        n = $countones(e);
        ch_q.delete();
        t_q.delete();
        reg_wr(ADDR_MAIN_CFG, 8'h00);
        seq_check(e, n, (rc == 0) ? n * (lat + 2) : IV[rc]);
      end
    end
    // One-shot from standby runs exactly one sequence
    for (int j = 0; j < 3; j++) begin
      d = 8'($random(seed));
      e = (d[4:0] == 5'h0) ? 5'h09 : d[4:0];
      reg_wr(ADDR_MAIN_CFG, 8'h40);
      wait_idle();
      reg_wr(ADDR_CHAN_EN, {3'h0, e});
      ch_q.delete();
      reg_wr(ADDR_ONE_SHOT, d);
      chk("busy", 1, busy);
      tick(IV[3] + 100);
      chk("starts", $countones(e), ch_q.size());
      chk("busy", 0, busy);
      reg_rd(ADDR_ONE_SHOT, 8'h00);
    end
    summarize();
  end
endmodule : testbench
